//--- jtc_pkg.sv
// Package with offsets, field layouts, reset values and carrier types of the codec table registers
`default_nettype none
package jtc_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;

    // Register byte offsets
    localparam logic [11:0] OFS_HUFF_SEL = 12'h010;
    localparam logic [11:0] OFS_DRI_HI = 12'h014;
    localparam logic [11:0] OFS_DRI_LO = 12'h018;
    localparam logic [11:0] OFS_VSIZE_HI = 12'h01c;
    localparam logic [11:0] OFS_VSIZE_LO = 12'h020;
    localparam logic [11:0] OFS_HSIZE_HI = 12'h024;
    localparam logic [11:0] OFS_HSIZE_LO = 12'h028;
    localparam logic [11:0] OFS_RST_OP = 12'h038;
    localparam logic [11:0] OFS_RST_STAT = 12'h03c;
    localparam logic [11:0] OFS_MKR = 12'h040;
    localparam logic [11:0] OFS_Q0 = 12'h400;
    localparam logic [11:0] OFS_Q1 = 12'h500;
    localparam logic [11:0] OFS_DC0_LEN = 12'h800;
    localparam logic [11:0] OFS_DC0_VAL = 12'h840;
    localparam logic [11:0] OFS_AC0_LEN = 12'h880;
    localparam logic [11:0] OFS_AC0_VAL = 12'h8c0;
    localparam logic [11:0] OFS_DC1_LEN = 12'hc00;
    localparam logic [11:0] OFS_DC1_VAL = 12'hc40;
    localparam logic [11:0] OFS_AC1_LEN = 12'hc80;
    localparam logic [11:0] OFS_AC1_VAL = 12'hcc0;

    // Entry counts of the byte arrays
    localparam int MKR_BYTES = 36;
    localparam int Q_ENTRIES = 64;
    localparam int LEN_ENTRIES = 16;
    localparam int DC_VAL_ENTRIES = 12;
    localparam int AC_VAL_ENTRIES = 162;

    // Field positions and codes
    localparam int STAT_CORR_BIT = 7;
    localparam int STAT_ERR_LSB = 3;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_RST_INTERVAL = 4'hb;
    localparam logic [3:0] ERR_IMAGE_SIZE = 4'hc;
    localparam logic [1:0] CAP_YUV_LOW = 2'h3;
    localparam logic [7:0] MKR_RESET = 8'hff;

    typedef enum logic [1:0] {
        RSTOP_OFF = 2'h0,
        RSTOP_DETECT = 2'h1,
        RSTOP_CORRECT = 2'h2,
        RSTOP_RSVD = 2'h3
    } jtc_rstop_t;

    typedef enum logic [3:0] {
        TBL_Q0 = 4'h0,
        TBL_Q1 = 4'h1,
        TBL_DC0_LEN = 4'h2,
        TBL_DC0_VAL = 4'h3,
        TBL_AC0_LEN = 4'h4,
        TBL_AC0_VAL = 4'h5,
        TBL_DC1_LEN = 4'h6,
        TBL_DC1_VAL = 4'h7,
        TBL_AC1_LEN = 4'h8,
        TBL_AC1_VAL = 4'h9
    } jtc_tbl_t;

    typedef struct packed {
        logic v_ac;
        logic v_dc;
        logic u_ac;
        logic u_dc;
        logic y_ac;
        logic y_dc;
    } jtc_huff_sel_t;

    // Events reported by the codec core
    typedef struct packed {
        logic err_valid;
        logic [3:0] err_code;
        logic corr_applied;
        logic size_valid;
        logic [15:0] vsize;
        logic [15:0] hsize;
        logic done;
    } jtc_core_evt_t;

    typedef struct packed {
        jtc_huff_sel_t huff_sel;
        logic [15:0] dri;
        logic [15:0] vsize;
        logic [15:0] hsize;
        jtc_rstop_t rst_op;
        logic corr;
        logic [3:0] err;
        logic [MKR_BYTES-1:0][7:0] mkr;
        logic [Q_ENTRIES-1:0][7:0] q0;
        logic [Q_ENTRIES-1:0][7:0] q1;
        logic [LEN_ENTRIES-1:0][7:0] dc0_len;
        logic [DC_VAL_ENTRIES-1:0][3:0] dc0_val;
        logic [LEN_ENTRIES-1:0][7:0] ac0_len;
        logic [AC_VAL_ENTRIES-1:0][7:0] ac0_val;
        logic [LEN_ENTRIES-1:0][7:0] dc1_len;
        logic [DC_VAL_ENTRIES-1:0][3:0] dc1_val;
        logic [LEN_ENTRIES-1:0][7:0] ac1_len;
        logic [AC_VAL_ENTRIES-1:0][7:0] ac1_val;
        logic [15:0] rdata;
        logic [7:0] tbl_data;
        logic [7:0] mkr_data;
        logic end_req;
    } jtc_state_t;

    // Enum member named explicitly so that no untyped zero lands in it
    localparam jtc_state_t ST_RESET = '{
        rst_op: RSTOP_OFF,
        mkr: {MKR_BYTES{MKR_RESET}},
        mkr_data: MKR_RESET,
        default: '0
    };

endpackage : jtc_pkg
`default_nettype wire

//--- jtc_table_regs.sv
// Codec table, size, restart and marker registers with core-side table read ports
`timescale 1ns/1ps
`default_nettype none
module jtc_table_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [jtc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [jtc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [jtc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic encode_decode_select,
    input wire logic marker_insert_en,
    input wire logic [2:0] capture_mode,
    input wire logic core_op_start,
    input wire jtc_pkg::jtc_core_evt_t core_evt,
    input wire jtc_pkg::jtc_tbl_t core_tbl_sel,
    input wire logic [7:0] core_tbl_idx,
    output logic [7:0] core_tbl_data,
    input wire logic [5:0] core_mkr_idx,
    output logic [7:0] core_mkr_data,
    output jtc_pkg::jtc_huff_sel_t huff_sel_out,
    output logic [15:0] restart_interval_value,
    output logic restart_markers_en,
    output logic restart_def_marker_en,
    output logic [15:0] vsize_out,
    output logic [15:0] hsize_out,
    output logic stop_on_error,
    output logic correct_errors,
    output logic mkr_insert_active,
    output logic codec_end_req
);
    import jtc_pkg::*;

    jtc_state_t st_reg;
    jtc_state_t st_next;
    logic decoding;
    logic size_hidden;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    function automatic logic hit(input logic [11:0] a, input logic [11:0] base, input int cnt);
        int ai;
        int bi;
        ai = int'(a);
        bi = int'(base);
        return (a[1:0] == 2'h0) && (ai >= bi) && (ai < bi + 4 * cnt);
    endfunction : hit

    function automatic logic [7:0] word_idx(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        return d[9:2];
    endfunction : word_idx

    assign decoding = encode_decode_select;
    assign size_hidden = (capture_mode[1:0] == CAP_YUV_LOW);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [7:0] wi;
        logic [7:0] ti;
        st_next = st_reg;
        st_next.rdata = '0;
        st_next.end_req = 1'b0;
        st_next.tbl_data = '0;
        wi = 8'h0;
        ti = core_tbl_idx;

        // Software writes; table arrays have no read path back to software
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_HUFF_SEL: st_next.huff_sel = reg_wdata[5:0];
                OFS_DRI_HI: st_next.dri[15:8] = reg_wdata[7:0];
                OFS_DRI_LO: st_next.dri[7:0] = reg_wdata[7:0];
                OFS_VSIZE_HI: st_next.vsize[15:8] = reg_wdata[7:0];
                OFS_VSIZE_LO: st_next.vsize[7:0] = reg_wdata[7:0];
                OFS_HSIZE_HI: st_next.hsize[15:8] = reg_wdata[7:0];
                OFS_HSIZE_LO: st_next.hsize[7:0] = reg_wdata[7:0];
                OFS_RST_OP: st_next.rst_op = jtc_rstop_t'(reg_wdata[1:0]);
                default: begin
                    wi = word_idx(reg_addr, OFS_MKR);
                    if (hit(reg_addr, OFS_MKR, MKR_BYTES)) begin
                        st_next.mkr[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_Q0);
                    if (hit(reg_addr, OFS_Q0, Q_ENTRIES)) begin
                        st_next.q0[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_Q1);
                    if (hit(reg_addr, OFS_Q1, Q_ENTRIES)) begin
                        st_next.q1[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_DC0_LEN);
                    if (hit(reg_addr, OFS_DC0_LEN, LEN_ENTRIES)) begin
                        st_next.dc0_len[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_DC0_VAL);
                    if (hit(reg_addr, OFS_DC0_VAL, DC_VAL_ENTRIES)) begin
                        st_next.dc0_val[wi] = reg_wdata[3:0];
                    end
                    wi = word_idx(reg_addr, OFS_AC0_LEN);
                    if (hit(reg_addr, OFS_AC0_LEN, LEN_ENTRIES)) begin
                        st_next.ac0_len[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_AC0_VAL);
                    if (hit(reg_addr, OFS_AC0_VAL, AC_VAL_ENTRIES)) begin
                        st_next.ac0_val[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_DC1_LEN);
                    if (hit(reg_addr, OFS_DC1_LEN, LEN_ENTRIES)) begin
                        st_next.dc1_len[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_DC1_VAL);
                    if (hit(reg_addr, OFS_DC1_VAL, DC_VAL_ENTRIES)) begin
                        st_next.dc1_val[wi] = reg_wdata[3:0];
                    end
                    wi = word_idx(reg_addr, OFS_AC1_LEN);
                    if (hit(reg_addr, OFS_AC1_LEN, LEN_ENTRIES)) begin
                        st_next.ac1_len[wi] = reg_wdata[7:0];
                    end
                    wi = word_idx(reg_addr, OFS_AC1_VAL);
                    if (hit(reg_addr, OFS_AC1_VAL, AC_VAL_ENTRIES)) begin
                        st_next.ac1_val[wi] = reg_wdata[7:0];
                    end
                end
            endcase
        end

        // Decoded file size overrides a software write in the same cycle
        if (decoding && core_evt.size_valid) begin
            st_next.vsize = core_evt.vsize;
            st_next.hsize = core_evt.hsize;
        end

        // Status clears at a new start; an event in that same cycle still lands
        if (core_op_start) begin
            st_next.corr = 1'b0;
            st_next.err = ERR_NONE;
        end
        if (decoding && st_reg.rst_op == RSTOP_DETECT && core_evt.err_valid) begin
            st_next.err = core_evt.err_code;
            st_next.end_req = 1'b1;
        end
        if (decoding && st_reg.rst_op == RSTOP_CORRECT && core_evt.corr_applied) begin
            st_next.corr = 1'b1;
        end
        if (core_evt.done) begin
            st_next.end_req = 1'b1;
        end

        // Register reads, answered one cycle later; write-only words read zero
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_HUFF_SEL: st_next.rdata = {10'h0, st_reg.huff_sel};
                OFS_DRI_HI: st_next.rdata = {8'h0, st_reg.dri[15:8]};
                OFS_DRI_LO: st_next.rdata = {8'h0, st_reg.dri[7:0]};
                OFS_VSIZE_HI: st_next.rdata = size_hidden ? 16'h0 : {8'h0, st_reg.vsize[15:8]};
                OFS_VSIZE_LO: st_next.rdata = size_hidden ? 16'h0 : {8'h0, st_reg.vsize[7:0]};
                OFS_HSIZE_HI: st_next.rdata = size_hidden ? 16'h0 : {8'h0, st_reg.hsize[15:8]};
                OFS_HSIZE_LO: st_next.rdata = size_hidden ? 16'h0 : {8'h0, st_reg.hsize[7:0]};
                OFS_RST_OP: st_next.rdata = {14'h0, st_reg.rst_op};
                OFS_RST_STAT: begin
                    st_next.rdata[STAT_CORR_BIT] = st_reg.corr;
                    st_next.rdata[STAT_ERR_LSB+:4] = st_reg.err;
                end
                default: begin
                    wi = word_idx(reg_addr, OFS_MKR);
                    if (hit(reg_addr, OFS_MKR, MKR_BYTES)) begin
                        st_next.rdata = {8'h0, st_reg.mkr[wi]};
                    end
                end
            endcase
        end

        // Core table port; decode never sees table contents
        if (!decoding) begin
            unique case (core_tbl_sel)
                TBL_Q0: if (ti < 8'(Q_ENTRIES)) st_next.tbl_data = st_reg.q0[ti];
                TBL_Q1: if (ti < 8'(Q_ENTRIES)) st_next.tbl_data = st_reg.q1[ti];
                TBL_DC0_LEN: if (ti < 8'(LEN_ENTRIES)) st_next.tbl_data = st_reg.dc0_len[ti];
                TBL_DC0_VAL: if (ti < 8'(DC_VAL_ENTRIES)) st_next.tbl_data = {4'h0, st_reg.dc0_val[ti]};
                TBL_AC0_LEN: if (ti < 8'(LEN_ENTRIES)) st_next.tbl_data = st_reg.ac0_len[ti];
                TBL_AC0_VAL: if (ti < 8'(AC_VAL_ENTRIES)) st_next.tbl_data = st_reg.ac0_val[ti];
                TBL_DC1_LEN: if (ti < 8'(LEN_ENTRIES)) st_next.tbl_data = st_reg.dc1_len[ti];
                TBL_DC1_VAL: if (ti < 8'(DC_VAL_ENTRIES)) st_next.tbl_data = {4'h0, st_reg.dc1_val[ti]};
                TBL_AC1_LEN: if (ti < 8'(LEN_ENTRIES)) st_next.tbl_data = st_reg.ac1_len[ti];
                TBL_AC1_VAL: if (ti < 8'(AC_VAL_ENTRIES)) st_next.tbl_data = st_reg.ac1_val[ti];
                default: st_next.tbl_data = 8'h0;
            endcase
        end

        // Out-of-range index gives padding bytes, so the core may walk all 64
        st_next.mkr_data = MKR_RESET;
        if (core_mkr_idx < 6'(MKR_BYTES)) begin
            st_next.mkr_data = st_reg.mkr[core_mkr_idx];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = st_reg.rdata;
    assign core_tbl_data = st_reg.tbl_data;
    assign core_mkr_data = st_reg.mkr_data;
    assign huff_sel_out = decoding ? '0 : st_reg.huff_sel;
    assign restart_interval_value = st_reg.dri;
    assign restart_markers_en = !decoding && (st_reg.dri != 16'h0);
    assign restart_def_marker_en = !decoding;
    assign vsize_out = st_reg.vsize;
    assign hsize_out = st_reg.hsize;
    // Reserved code 11 behaves like 00: no detection, no correction
    assign stop_on_error = decoding && st_reg.rst_op == RSTOP_DETECT;
    assign correct_errors = decoding && st_reg.rst_op == RSTOP_CORRECT;
    assign mkr_insert_active = marker_insert_en && !decoding;
    assign codec_end_req = st_reg.end_req;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_sel_dec;
        @(posedge ref_clk) disable iff (!rst_n) decoding |-> huff_sel_out == 6'h0;
    endproperty
    a_sel_dec: assert property (p_sel_dec) else $error("select visible while decoding");

    property p_sel_rd;
        @(posedge ref_clk) disable iff (!rst_n)
            reg_wr && reg_addr == OFS_HUFF_SEL ##1 reg_rd && reg_addr == OFS_HUFF_SEL
            |=> reg_rdata == {10'h0, $past(reg_wdata[5:0], 2)};
    endproperty
    a_sel_rd: assert property (p_sel_rd) else $error("select readback wrong");

    property p_dri_hi;
        @(posedge ref_clk) disable iff (!rst_n)
            reg_wr && reg_addr == OFS_DRI_HI |=> restart_interval_value[15:8] == $past(reg_wdata[7:0]);
    endproperty
    a_dri_hi: assert property (p_dri_hi) else $error("interval high byte not taken");

    property p_rst_zero;
        @(posedge ref_clk) disable iff (!rst_n)
            restart_interval_value == 16'h0 |-> !restart_markers_en;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("markers on with zero interval");

    property p_size_dec;
        @(posedge ref_clk) disable iff (!rst_n)
            decoding && core_evt.size_valid
            |=> vsize_out == $past(core_evt.vsize) && hsize_out == $past(core_evt.hsize);
    endproperty
    a_size_dec: assert property (p_size_dec) else $error("decoded size not captured");

    property p_size_hidden;
        @(posedge ref_clk) disable iff (!rst_n)
            reg_rd && size_hidden && reg_addr == OFS_VSIZE_LO |=> reg_rdata == 16'h0;
    endproperty
    a_size_hidden: assert property (p_size_hidden) else $error("size readable in capture");

    logic [3:0] reg_rd_err_q;
    assign reg_rd_err_q = st_reg.err;

    property p_detect;
        @(posedge ref_clk) disable iff (!rst_n)
            decoding && st_reg.rst_op == RSTOP_DETECT && core_evt.err_valid
            |=> codec_end_req && reg_rd_err_q == $past(core_evt.err_code);
    endproperty
    a_detect: assert property (p_detect) else $error("detected error not reported");

    property p_correct_no_end;
        @(posedge ref_clk) disable iff (!rst_n)
            correct_errors && core_evt.err_valid && !core_evt.done |=> !codec_end_req;
    endproperty
    a_correct_no_end: assert property (p_correct_no_end) else $error("early end in correction");

    property p_corr_flag;
        @(posedge ref_clk) disable iff (!rst_n)
            correct_errors && core_evt.corr_applied ##1 reg_rd && reg_addr == OFS_RST_STAT
            |=> reg_rdata[STAT_CORR_BIT];
    endproperty
    a_corr_flag: assert property (p_corr_flag) else $error("correction flag missing");

    property p_tbl_dec;
        @(posedge ref_clk) disable iff (!rst_n) decoding |=> core_tbl_data == 8'h0;
    endproperty
    a_tbl_dec: assert property (p_tbl_dec) else $error("table visible while decoding");

    property p_mkr_dec;
        @(posedge ref_clk) disable iff (!rst_n) decoding |-> !mkr_insert_active;
    endproperty
    a_mkr_dec: assert property (p_mkr_dec) else $error("marker insert while decoding");

    c_detect: cover property (@(posedge ref_clk) disable iff (!rst_n)
        stop_on_error && core_evt.err_valid ##1 codec_end_req);
    c_correct: cover property (@(posedge ref_clk) disable iff (!rst_n)
        correct_errors && core_evt.corr_applied);
    c_capture_rd: cover property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && size_hidden && reg_addr == OFS_VSIZE_LO);

endmodule : jtc_table_regs
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the codec table and configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import jtc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic encode_decode_select = 1'b0, marker_insert_en = 1'b0, core_op_start = 1'b0;
    logic [2:0] capture_mode = 3'h0;
    jtc_core_evt_t core_evt = '0, ev;
    jtc_tbl_t core_tbl_sel = TBL_Q0;
    logic [7:0] core_tbl_idx = 8'h00, core_tbl_data, core_mkr_data;
    logic [5:0] core_mkr_idx = 6'h00;
    jtc_huff_sel_t huff_sel_out;
    logic [15:0] restart_interval_value, vsize_out, hsize_out;
    logic restart_markers_en, restart_def_marker_en, stop_on_error, correct_errors;
    logic mkr_insert_active, codec_end_req;
    int failures = 0, samples_checked = 0;
    jtc_table_regs u_jtc_table_regs (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .encode_decode_select(encode_decode_select), .marker_insert_en(marker_insert_en),
        .capture_mode(capture_mode), .core_op_start(core_op_start), .core_evt(core_evt),
        .core_tbl_sel(core_tbl_sel), .core_tbl_idx(core_tbl_idx), .core_tbl_data(core_tbl_data),
        .core_mkr_idx(core_mkr_idx), .core_mkr_data(core_mkr_data), .huff_sel_out(huff_sel_out),
        .restart_interval_value(restart_interval_value), .restart_markers_en(restart_markers_en),
        .restart_def_marker_en(restart_def_marker_en), .vsize_out(vsize_out),
        .hsize_out(hsize_out), .stop_on_error(stop_on_error), .correct_errors(correct_errors),
        .mkr_insert_active(mkr_insert_active), .codec_end_req(codec_end_req));
    always #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd
    task automatic event_pulse(input jtc_core_evt_t e);
        @(posedge ref_clk);
        core_evt <= e;
        @(posedge ref_clk);
        core_evt <= '0;
        #1;
    endtask : event_pulse
    task automatic tbl(input jtc_tbl_t s, input logic [7:0] i, input logic [7:0] exp);
        @(posedge ref_clk);
        core_tbl_sel <= s;
        core_tbl_idx <= i;
        @(posedge ref_clk);
        #1;
        check(core_tbl_data, exp);
    endtask : tbl
    task automatic op_start();
        @(posedge ref_clk);
        core_op_start <= 1'b1;
        @(posedge ref_clk);
        core_op_start <= 1'b0;
    endtask : op_start
    // Watchdog so that a stuck run still reaches the verdict
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 12; k++) rd(12'h010 + 12'(4 * k), (k >= 12'h0c) ? 16'h00ff : 16'h0000);
        check(core_mkr_data, 16'h00ff);
        $display("test reset_values done");
        wr(OFS_HUFF_SEL, 16'h003c);
        check(huff_sel_out, 16'h003c);
        rd(OFS_HUFF_SEL, 16'h003c);
        wr(OFS_DRI_HI, 16'h0012);
        wr(OFS_DRI_LO, 16'h0034);
        check(restart_interval_value, 16'h1234);
        check(restart_markers_en, 16'h0001);
        wr(OFS_DRI_HI, 16'h0000);
        wr(OFS_DRI_LO, 16'h0000);
        check({restart_markers_en, restart_def_marker_en}, 16'h0001);
        marker_insert_en <= 1'b1;
        wr(OFS_MKR + 12'h08c, 16'h005a);
        check(mkr_insert_active, 16'h0001);
        core_mkr_idx <= 6'd35;
        tbl(TBL_Q0, 8'h00, 8'h00);
        check(core_mkr_data, 16'h005a);
        core_mkr_idx <= 6'd36;
        wr(OFS_Q0 + 12'h00c, 16'h00a5);
        check(core_mkr_data, 16'h00ff);
        rd(OFS_MKR + 12'h08c, 16'h005a);
        wr(OFS_Q1 + 12'h0fc, 16'h0077);
        wr(OFS_DC0_VAL + 12'h004, 16'h00f7);
        wr(OFS_AC0_VAL + 12'h284, 16'h003e);
        tbl(TBL_Q0, 8'd3, 8'ha5);
        tbl(TBL_Q1, 8'd63, 8'h77);
        tbl(TBL_DC0_VAL, 8'd1, 8'h07);
        tbl(TBL_AC0_VAL, 8'd161, 8'h3e);
        rd(OFS_Q0 + 12'h00c, 16'h0000);
        rd(12'h030, 16'h0000);
        $display("test encode_setup done");
        wr(OFS_VSIZE_HI, 16'h0012);
        wr(OFS_VSIZE_LO, 16'h0034);
        wr(OFS_HSIZE_HI, 16'h0056);
        wr(OFS_HSIZE_LO, 16'h0078);
        check(vsize_out, 16'h1234);
        check(hsize_out, 16'h5678);
        rd(OFS_HSIZE_LO, 16'h0078);
        capture_mode <= 3'h3;
        rd(OFS_VSIZE_HI, 16'h0000);
        capture_mode <= 3'h0;
        $display("test sizes done");
        wr(OFS_RST_OP, 16'h0001);
        check(stop_on_error, 16'h0000);
        encode_decode_select <= 1'b1;
        tbl(TBL_Q0, 8'd3, 8'h00);
        check({huff_sel_out, mkr_insert_active}, 16'h0000);
        ev = '0;
        ev.size_valid = 1'b1;
        ev.vsize = 16'h0280;
        ev.hsize = 16'h01e0;
        event_pulse(ev);
        check(vsize_out, 16'h0280);
        rd(OFS_HSIZE_HI, 16'h0001);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_RST_OP, 16'(m));
            check({stop_on_error, correct_errors}, 16'(m == 1 ? 2 : m == 2 ? 1 : 0));
            op_start();
            ev = '0;
            ev.err_valid = 1'b1;
            ev.err_code = ERR_RST_INTERVAL;
            ev.corr_applied = 1'b1;
            event_pulse(ev);
            check(codec_end_req, 16'(m == 1));
            rd(OFS_RST_STAT, m == 1 ? 16'h0058 : m == 2 ? 16'h0080 : 16'h0000);
        end
        ev = '0;
        ev.done = 1'b1;
        event_pulse(ev);
        check(codec_end_req, 16'h0001);
        wr(OFS_RST_OP, 16'h0001);
        op_start();
        ev = '0;
        ev.err_valid = 1'b1;
        ev.err_code = ERR_IMAGE_SIZE;
        event_pulse(ev);
        wr(OFS_RST_STAT, 16'h0000);
        rd(OFS_RST_STAT, 16'h0060);
        op_start();
        rd(OFS_RST_STAT, 16'h0000);
        $display("test decode_status done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
